// ---- shared/mxc_map.svh ----
// offsets, field positions, reset values and timing counts of the
// crossover extended control block; included by mxc_ctrl and the bench
`ifndef MXC_MAP_SVH
`define MXC_MAP_SVH

// management address of extended control register two
`define MXC_ECR2_ADDR 5'h13
// field positions
`define MXC_BIT_NODE 15
`define MXC_BIT_SWMODE 14
`define MXC_BIT_RFAULT 13
`define MXC_BIT_XEN 9
`define MXC_BIT_FSEL 8
`define MXC_BIT_TRI 7
`define MXC_BIT_APD 0
// remote fault position inside the partner link control word
`define MXC_LCW_RF_BIT 13
// reset value and writable bits
`define MXC_ECR2_RESET 16'h4201
`define MXC_ECR2_WMASK 16'h1BFF
// interval between arrangement swaps while hunting for link
`define MXC_CLK_NS 4
`define MXC_SWAP_NS 10000
`define MXC_SWAP_CYC (`MXC_SWAP_NS / `MXC_CLK_NS)

`endif

// ---- shared/mxc_pkg.sv ----
// types of the crossover extended control block
// assumes mxc_map.svh supplies the numbers
package mxc_pkg;

  // one management access, one cycle wide
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mxc_mgmt_req_t;

  // the four twisted-pair line pins
  typedef struct packed {
    logic a_p;
    logic a_n;
    logic b_p;
    logic b_n;
  } mxc_pair_t;

  // pair arrangement, one-hot
  typedef enum logic [1:0] {
    MXC_STRAIGHT = 2'b01,
    MXC_CROSS = 2'b10
  } mxc_arr_t;

endpackage : mxc_pkg

// ---- design/mxc_sync.sv ----
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/1ps
module mxc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // first stage read only by second stage
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        meta_r[gi] <= async_in[gi];
        sync_out[gi] <= meta_r[gi];
      end
    end
  endgenerate
endmodule : mxc_sync

// ---- design/mxc_ctrl.sv ----
// crossover, tri-state, power-down and strap/led logic behind
// extended control register two
// assumes same-clock management port and link status inputs
//
// Functional notes
// - remote fault bit reads the same as partner ability fault bit
// - remote fault follows fault flag in received partner link word
// - arrangement picked automatically by swapping transmit and receive
// - auto crossover on after reset; enable bit 1, select bit 0
// - enable bit zero ignores pin; select 0 straight, 1 cross
// - pin low with enable bit one forces straight regardless of select bit
// - automatic choice only when pin and enable bit both one
// - straight: transmit A receive B; cross: transmit B receive A
// - tri-state bit one floats transmit outputs
// - auto power-down bit with 10 Mb/s link powers down 100 path
// - isolate also powers down the 100 path
// - enable and select sit at address 13h bits nine and eight
// - five shared pins give address bits, then drive status leds
// - speed output high at 100 Mb/s with link up, low otherwise
`timescale 1ns/1ps
`include "mxc_map.svh"
module mxc_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input mxc_pkg::mxc_mgmt_req_t mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic auto_crossover_enable_pin,
  input wire logic [15:0] partner_lcw,
  input wire logic partner_lcw_valid,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic isolate,
  input wire logic line_transmit_plus,
  input wire logic line_transmit_minus,
  input mxc_pkg::mxc_pair_t pair_in,
  output mxc_pkg::mxc_pair_t pair_out,
  output mxc_pkg::mxc_pair_t pair_oe,
  output logic rx_plus,
  output logic rx_minus,
  input wire logic [4:0] led_status,
  input wire logic [4:0] led_pin_in,
  output logic [4:0] led_pin_out,
  output logic [4:0] led_pin_oe,
  output logic [4:0] phy_address_bits,
  output logic speed_indication,
  output logic pwrdn_100tx,
  output logic crossed
);
  import mxc_pkg::*;

  // led drive: asserted state is the inverse of the strapped sense
  function automatic logic led_level(input logic sense, input logic on);
    led_level = on ^ sense;
  endfunction : led_level

  logic [9:0] pins_s;
  logic xen_pin_s;
  logic [4:0] straps_s;
  mxc_pair_t pair_s;
  logic [15:0] ecr2_r;
  logic [15:0] ecr2_nxt;
  logic rf_r;
  mxc_arr_t arr_r;
  mxc_arr_t arr_nxt;
  logic [11:0] swap_cnt_r;
  logic in_rst_r;
  logic [15:0] rdata_w;
  logic hit_w;
  logic auto_w;
  logic swap_tick_w;
  logic cross_w;

  // every pin level passes two flops first
  mxc_sync #(.W(10)) u_sync (
    .mclk(mclk),
    .async_in({auto_crossover_enable_pin, led_pin_in, pair_in}),
    .sync_out(pins_s)
  );
  assign xen_pin_s = pins_s[9];
  assign straps_s = pins_s[8:4];
  assign pair_s = pins_s[3:0];

  // register decode and write merge
  assign hit_w = (mgmt_req.addr == `MXC_ECR2_ADDR);
  assign ecr2_nxt = (mgmt_req.wdata & `MXC_ECR2_WMASK)
                  | (ecr2_r & ~`MXC_ECR2_WMASK);
  // read view: fixed mode bits, live fault, stored controls
  assign rdata_w = {1'b0, 1'b1, rf_r, ecr2_r[12:0]};

  // register store; reset enables auto crossover
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ecr2_r <= `MXC_ECR2_RESET;
    else if (mgmt_req.wr && hit_w)
      ecr2_r <= ecr2_nxt;
  end

  // read answer one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      mgmt_rvalid <= mgmt_req.rd && hit_w;
      if (mgmt_req.rd && hit_w)
        mgmt_rdata <= rdata_w;
    end
  end

  // remote fault copied from each received partner word
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rf_r <= 1'b0;
    else if (partner_lcw_valid)
      rf_r <= partner_lcw[`MXC_LCW_RF_BIT];
  end

  // automatic mode needs pin and enable bit both high
  assign auto_w = xen_pin_s && ecr2_r[`MXC_BIT_XEN];
  assign swap_tick_w = (swap_cnt_r == 12'(`MXC_SWAP_CYC - 1));

  // swap interval divider, runs while hunting
  always_ff @(posedge mclk)
  begin
    if (sys_rst || swap_tick_w || link_up || !auto_w)
      swap_cnt_r <= 12'h000;
    else
      swap_cnt_r <= swap_cnt_r + 12'h001;
  end

  // arrangement selection
  always_comb
  begin
    arr_nxt = arr_r;
    if (!ecr2_r[`MXC_BIT_XEN])
      arr_nxt = ecr2_r[`MXC_BIT_FSEL] ? MXC_CROSS : MXC_STRAIGHT;
    else if (!xen_pin_s)
      arr_nxt = MXC_STRAIGHT;
    else if (swap_tick_w && !link_up)
    begin
      case (arr_r)
        MXC_STRAIGHT: arr_nxt = MXC_CROSS;
        MXC_CROSS: arr_nxt = MXC_STRAIGHT;
        default: arr_nxt = MXC_STRAIGHT;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      arr_r <= MXC_STRAIGHT;
    else
      arr_r <= arr_nxt;
  end
  assign cross_w = (arr_r == MXC_CROSS);

  // pair steering and tri-state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pair_out <= '0;
      pair_oe <= '0;
      rx_plus <= 1'b0;
      rx_minus <= 1'b0;
      crossed <= 1'b0;
    end
    else
    begin
      pair_out <= cross_w
        ? {2'b00, line_transmit_plus, line_transmit_minus}
        : {line_transmit_plus, line_transmit_minus, 2'b00};
      pair_oe <= ecr2_r[`MXC_BIT_TRI] ? 4'h0
        : (cross_w ? 4'h3 : 4'hC);
      rx_plus <= cross_w ? pair_s.a_p : pair_s.b_p;
      rx_minus <= cross_w ? pair_s.a_n : pair_s.b_n;
      crossed <= cross_w;
    end
  end

  // 100 Mb/s path power-down and speed pin
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pwrdn_100tx <= 1'b0;
      speed_indication <= 1'b0;
    end
    else
    begin
      pwrdn_100tx <= (ecr2_r[`MXC_BIT_APD] && link_up && !speed_100)
                   || isolate;
      speed_indication <= speed_100 && link_up;
    end
  end

  // straps sampled on the first edge after reset release
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      in_rst_r <= 1'b1;
    else
      in_rst_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      phy_address_bits <= 5'h00;
    else if (in_rst_r)
      phy_address_bits <= straps_s;
  end

  // shared pins: inputs during reset, led drivers afterwards
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_led
      always_ff @(posedge mclk)
      begin
        if (sys_rst || in_rst_r)
        begin
          led_pin_out[gi] <= 1'b0;
          led_pin_oe[gi] <= 1'b0;
        end
        else
        begin
          led_pin_out[gi] <= led_level(phy_address_bits[gi],
                                       led_status[gi]);
          led_pin_oe[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // checks
  AST_RF_READ: assert property (@(posedge mclk) disable iff (sys_rst)
    mgmt_req.rd && hit_w |=> mgmt_rvalid
      && mgmt_rdata[`MXC_BIT_RFAULT] == $past(rf_r))
    else $error("remote fault read mismatch");
  AST_RF_FOLLOW: assert property (@(posedge mclk)
    disable iff (sys_rst)
    partner_lcw_valid |=> rf_r == $past(partner_lcw[`MXC_LCW_RF_BIT]))
    else $error("remote fault not taken from partner word");
  AST_RESET_DEF: assert property (@(posedge mclk)
    sys_rst |=> ecr2_r[`MXC_BIT_XEN] && !ecr2_r[`MXC_BIT_FSEL])
    else $error("crossover defaults wrong after reset");
  AST_FORCED: assert property (@(posedge mclk) disable iff (sys_rst)
    !ecr2_r[`MXC_BIT_XEN] |=> cross_w == $past(ecr2_r[`MXC_BIT_FSEL]))
    else $error("forced arrangement not applied");
  AST_PIN_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
    ecr2_r[`MXC_BIT_XEN] && !xen_pin_s |=> !cross_w)
    else $error("pin low did not force straight");
  AST_HOLD_LINK: assert property (@(posedge mclk)
    disable iff (sys_rst) auto_w && link_up ##1 auto_w |-> $stable(arr_r))
    else $error("arrangement changed with link up");
  AST_TX_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
    !ecr2_r[`MXC_BIT_TRI] && cross_w ##1 !ecr2_r[`MXC_BIT_TRI]
      |-> pair_oe == 4'h3)
    else $error("cross arrangement not on pair B");
  AST_TRISTATE: assert property (@(posedge mclk) disable iff (sys_rst)
    ecr2_r[`MXC_BIT_TRI] |=> pair_oe == 4'h0)
    else $error("transmit pins driven while tri-stated");
  AST_PWRDN: assert property (@(posedge mclk) disable iff (sys_rst)
    isolate || (ecr2_r[`MXC_BIT_APD] && link_up && !speed_100)
      |=> pwrdn_100tx)
    else $error("100 path not powered down");
  AST_LED_OE: assert property (@(posedge mclk)
    sys_rst ##1 !sys_rst |=> led_pin_oe == 5'h00 ##1 led_pin_oe == 5'h1F)
    else $error("shared pins not turned to outputs");
  AST_SPEED: assert property (@(posedge mclk) disable iff (sys_rst)
    !link_up |=> !speed_indication)
    else $error("speed output high without link");
  AST_SPD_ON: assert property (@(posedge mclk) disable iff (sys_rst)
    speed_100 && link_up |=> speed_indication)
    else $error("speed output low at 100 with link");
  AST_APD_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
    !isolate && !ecr2_r[`MXC_BIT_APD] |=> !pwrdn_100tx)
    else $error("100 path powered down without cause");
  AST_TX_STR: assert property (@(posedge mclk) disable iff (sys_rst)
    !ecr2_r[`MXC_BIT_TRI] && !cross_w |=> pair_oe == 4'hC)
    else $error("straight arrangement not on pair A");
  AST_RX_CRS: assert property (@(posedge mclk) disable iff (sys_rst)
    cross_w |=> rx_plus == $past(pair_s.a_p)
      && rx_minus == $past(pair_s.a_n))
    else $error("cross receive not taken from pair A");
  AST_RX_STR: assert property (@(posedge mclk) disable iff (sys_rst)
    !cross_w |=> rx_plus == $past(pair_s.b_p)
      && rx_minus == $past(pair_s.b_n))
    else $error("straight receive not taken from pair B");
  AST_STRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    in_rst_r |=> phy_address_bits == $past(straps_s))
    else $error("address straps not latched");
  AST_WR_CTRL: assert property (@(posedge mclk) disable iff (sys_rst)
    mgmt_req.wr && hit_w |=> ecr2_r[`MXC_BIT_XEN:`MXC_BIT_FSEL]
      == $past(mgmt_req.wdata[`MXC_BIT_XEN:`MXC_BIT_FSEL]))
    else $error("crossover controls not written");
  AST_SWAP: assert property (@(posedge mclk) disable iff (sys_rst)
    auto_w && !link_up && swap_tick_w |=> $changed(arr_r))
    else $error("no arrangement swap while hunting");
endmodule : mxc_ctrl

// ---- sim/mxc_sta.sv ----
// station management model that issues register accesses
// assumes requests launch at mclk rising edges, one per cycle
`timescale 1ns/1ps
module mxc_sta (
  input wire logic mclk,
  output mxc_pkg::mxc_mgmt_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  import mxc_pkg::*;

  // idle bus value, no access pending
  initial mgmt_req = '0;

  // write pulse; reserved bits go out at their defaults
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    mgmt_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d & 16'hE381};
    @(posedge mclk);
    mgmt_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // read pulse, then a bounded wait for the answer
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
    output logic ok);
    int i;
    d = 'x;
    ok = 1'b0;
    @(posedge mclk);
    mgmt_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0};
    @(posedge mclk);
    mgmt_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (mgmt_rvalid === 1'b1 && !ok)
      begin
        d = mgmt_rdata;
        ok = 1'b1;
      end
      @(posedge mclk);
    end
  endtask : rd
endmodule : mxc_sta

// ---- sim/tb.sv ----
// self-checking bench for the crossover extended control block
// assumes mxc_ctrl, mxc_sync and the management model mxc_sta
`timescale 1ns/1ps
`include "mxc_map.svh"
module tb;
  import mxc_pkg::*;
  localparam logic [4:0] STRAP = 5'h15;
  localparam logic [4:0] A = `MXC_ECR2_ADDR;
  logic mclk, sys_rst, mgmt_rvalid, auto_crossover_enable_pin;
  logic partner_lcw_valid, link_up, speed_100, isolate;
  logic line_transmit_plus, line_transmit_minus, rx_plus, rx_minus;
  logic speed_indication, pwrdn_100tx, crossed;
  logic [15:0] mgmt_rdata, partner_lcw, d;
  logic [4:0] led_status, led_pin_in, led_pin_out, led_pin_oe;
  logic [4:0] phy_address_bits;
  logic ok;
  mxc_mgmt_req_t mgmt_req;
  mxc_pair_t pair_in, pair_out, pair_oe, far_pair;
  int failures = 0;
  int n_tests = 0;

  // wire levels: driven by whoever has its enable up
  assign pair_in = (pair_oe & pair_out) | (~pair_oe & far_pair);
  assign led_pin_in = (led_pin_oe & led_pin_out) | (~led_pin_oe & STRAP);

  mxc_ctrl u_mxc_ctrl (.mclk, .sys_rst, .mgmt_req, .mgmt_rdata,
    .mgmt_rvalid, .auto_crossover_enable_pin, .partner_lcw,
    .partner_lcw_valid, .link_up, .speed_100, .isolate,
    .line_transmit_plus, .line_transmit_minus, .pair_in, .pair_out,
    .pair_oe, .rx_plus, .rx_minus, .led_status, .led_pin_in,
    .led_pin_out, .led_pin_oe, .phy_address_bits, .speed_indication,
    .pwrdn_100tx, .crossed);
  mxc_sta u_mxc_sta (.mclk, .mgmt_req, .mgmt_rdata, .mgmt_rvalid);

  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
        seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic stop_test;
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // steering of transmit, enables and receive for one arrangement
  task automatic chk_arr(input logic x);
    chk(crossed, x, "crossed");
    chk(pair_oe, x ? 4'h3 : 4'hC, "pair enables");
    chk(pair_out & pair_oe, x ? 4'h2 : 4'h8, "tx pair");
    chk({rx_plus, rx_minus}, x ? 2'b01 : 2'b10, "rx pair");
  endtask : chk_arr

  // reset values, straps and led sense
  task automatic t_reset;
    u_mxc_sta.rd(A, d, ok);
    chk(d, 16'h4201, "reset value");
    chk(phy_address_bits, STRAP, "strap");
    chk(led_pin_oe, 5'h1F, "led enables");
    @(posedge mclk);
    led_status <= 5'h03;
    cyc(6);
    chk(led_pin_out, 5'h16, "led levels");
  endtask : t_reset

  // read-only bits, unmapped address
  task automatic t_regs;
    u_mxc_sta.wr(A, 16'hFFFF);
    u_mxc_sta.wr(5'h12, 16'h0000);
    u_mxc_sta.rd(A, d, ok);
    chk(d, 16'h4381, "ecr2 readback");
    u_mxc_sta.rd(5'h12, d, ok);
    chk(ok, 1'b0, "unmapped answer");
  endtask : t_regs

  // pin, enable bit, select bit combinations outside auto mode
  task automatic t_forced;
    int k;
    for (k = 0; k < 8; k++)
    begin
      if (k[2:1] != 2'b11)
      begin
        @(posedge mclk);
        auto_crossover_enable_pin <= k[2];
        u_mxc_sta.wr(A, {6'h0, k[1], k[0], 8'h0});
        cyc(8);
        chk_arr(k[1] ? 1'b0 : k[0]);
      end
    end
    u_mxc_sta.wr(A, 16'h0080);
    cyc(4);
    chk(pair_oe, 4'h0, "tristate");
    u_mxc_sta.wr(A, 16'h0000);
    cyc(4);
    chk(pair_oe, 4'hC, "tristate off");
  endtask : t_forced

  // automatic hunting while link is down, held while up
  task automatic t_auto;
    int n, m;
    logic c;
    @(posedge mclk);
    auto_crossover_enable_pin <= 1'b1;
    u_mxc_sta.wr(A, 16'h0200);
    for (m = 0; m < 2; m++)
    begin
      c = crossed;
      n = 0;
      while (crossed === c && n < 2 * `MXC_SWAP_CYC + 10)
      begin
        cyc(1);
        n++;
      end
    end
    chk(n >= `MXC_SWAP_CYC - 3 && n <= `MXC_SWAP_CYC + 3, 1'b1,
      "swap interval");
    @(posedge mclk);
    link_up <= 1'b1;
    cyc(4);
    c = crossed;
    n = 0;
    repeat (2 * `MXC_SWAP_CYC)
    begin
      cyc(1);
      n += (crossed !== c);
    end
    chk(n, 0, "swap with link");
  endtask : t_auto

  // automatic power-down, isolate, speed indication
  task automatic t_power;
    u_mxc_sta.wr(A, 16'h0001);
    cyc(4);
    chk(pwrdn_100tx, 1'b1, "apd at 10");
    @(posedge mclk);
    speed_100 <= 1'b1;
    cyc(4);
    chk({pwrdn_100tx, speed_indication}, 2'b01, "at 100");
    @(posedge mclk);
    link_up <= 1'b0;
    cyc(4);
    chk(speed_indication, 1'b0, "no link");
    @(posedge mclk);
    link_up <= 1'b1;
    speed_100 <= 1'b0;
    u_mxc_sta.wr(A, 16'h0000);
    cyc(4);
    chk(pwrdn_100tx, 1'b0, "apd off");
    @(posedge mclk);
    isolate <= 1'b1;
    cyc(4);
    chk(pwrdn_100tx, 1'b1, "isolate");
  endtask : t_power

  // remote fault taken from the partner link word
  task automatic t_fault;
    int k;
    for (k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      partner_lcw <= k ? 16'hDFFF : 16'h2000;
      partner_lcw_valid <= 1'b1;
      @(posedge mclk);
      partner_lcw <= k ? 16'h2000 : 16'hDFFF;
      partner_lcw_valid <= 1'b0;
      u_mxc_sta.rd(A, d, ok);
      chk(d, k ? 16'h4000 : 16'h6000, "remote fault");
    end
  endtask : t_fault

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // watchdog
  initial
  begin
    #200000;
    failures++;
    stop_test;
  end

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    auto_crossover_enable_pin = 1'b1;
    {partner_lcw, partner_lcw_valid, link_up, speed_100} = '0;
    {isolate, line_transmit_minus, led_status} = '0;
    line_transmit_plus = 1'b1;
    far_pair = 4'b0110;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    cyc(2);
    t_reset;
    t_regs;
    t_forced;
    t_auto;
    t_power;
    t_fault;
    stop_test;
  end
endmodule : tb
